/* src/nvm_command_register_interface.sv */
`timescale 1ns/1ns
// Overview of operation
// - command field bits 2:0 select none, write, erase, both, clear, chip, eeprom, fuse
// - fuse write is accepted only from the programming debug port
// - chip erase clears flash and eeprom, eeprom kept when save fuse is one
// - boot lock makes boot section reads and fetches return zero
// - boot lock written only from boot code, cleared only by reset
// - boot lock takes effect once execution first leaves boot section
// - app write protect blocks app writes, set only, reset clears
// - write error reads one when the last operation failed
// - eeprom busy reads one while eeprom executes a command
// - flash busy reads one while flash executes a command
// - eeprom ready interrupt is a level of enable and flag
// - ready flag held set while eeprom idle, write one clears it
// - data word low byte at 0x06, high byte at next offset
// - address word at 0x08 holds last updated location, high byte next
// - page buffer cleared after write, erase or erase-write completes
// - buffer clear fills ones and stalls the cpu seven cycles
// - page erase acts only if a buffer byte was written
// - command write from the cpu without valid key leaves register unchanged
module nvm_command_register_interface #(
	parameter int PB_AW = 6,
	parameter logic [15:0] BOOT_END = 16'h0800,
	parameter logic [15:0] APP_END = 16'h8000,
	parameter logic [15:0] EE_BASE = 16'h1400,
	parameter logic [15:0] EE_TOP = 16'h14FF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic dbg_master,
	input wire logic key_pulse,
	input wire logic instr_done,
	input wire logic [15:0] cpu_pc,
	input wire logic eeprom_save_fuse,
	input wire nvm_pkg::pb_wr_t pb_wr,
	input wire logic [PB_AW-1:0] pb_rd_idx,
	output logic [7:0] pb_rd_data,
	output logic pb_rd_written,
	input wire logic [15:0] rd_addr,
	input wire logic [15:0] mem_rdata,
	output logic [15:0] rd_data,
	input wire nvm_pkg::nvm_rsp_t nvm_rsp,
	output nvm_pkg::nvm_req_t nvm_req,
	output logic cpu_stall,
	output logic eeprom_ready_irq
);
	import nvm_pkg::*;
	localparam int PAGE_BYTES = 2 ** PB_AW;

	logic [7:0] page_buf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] pb_written;
	logic pb_any;
	logic pb_mixed;
	section_t pb_section;
	logic dph_write;
	logic dph_dbg;
	logic [IDX_W-1:0] dph_idx;
	logic [2:0] key_left;
	logic [CMD_W-1:0] command;
	logic app_write_protect;
	logic boot_lock_a;
	logic lock_pending;
	logic lock_active;
	logic write_error;
	logic ready_irq_en;
	logic eeprom_ready;
	logic [15:0] data_word;
	logic [15:0] addr_word;
	seq_state_t state;
	logic [3:0] stall_cnt;
	nvm_cmd_t run_cmd;
	logic [7:0] wbyte;
	logic cmd_wr;
	logic cmd_ok;
	logic cmd_go;
	logic cmd_fail;
	logic buf_clear;
	logic in_boot;
	nvm_cmd_t new_cmd;
	section_t target;
	logic [7:0] rd_byte;

	// address to section of the nonvolatile space
	function automatic section_t sec_of(input logic [15:0] a);
		if (a >= EE_BASE && a <= EE_TOP) begin
			sec_of = sec_eeprom;
		end else if (a < BOOT_END) begin
			sec_of = sec_boot;
		end else if (a < APP_END) begin
			sec_of = sec_app;
		end else begin
			sec_of = sec_data;
		end
	endfunction

	// bus never stalls and always answers okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign wbyte = hwdata[7:0];
	assign in_boot = (cpu_pc < BOOT_END);
	assign new_cmd = nvm_cmd_t'(wbyte[CMD_W-1:0]);
	assign target = pb_any ? pb_section : sec_of(addr_word);

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_write <= 1'b0;
			dph_dbg <= 1'b0;
			dph_idx <= '0;
		end else if (hready) begin
			dph_write <= hsel && htrans == HTRANS_NONSEQ && hwrite;
			dph_dbg <= dbg_master;
			dph_idx <= haddr[IDX_LSB +: IDX_W];
		end
	end

	// command write decode and acceptance
	assign cmd_wr = dph_write && dph_idx == IDX_COMMAND;
	assign cmd_ok = cmd_wr && (dph_dbg || key_left != 3'h0);
	always_comb begin
		cmd_go = 1'b0;
		cmd_fail = 1'b0;
		if (cmd_ok && state == st_idle) begin
			case (new_cmd)
				page_write_cmd, erase_write_page_cmd: begin
					cmd_fail = pb_mixed ||
						(target == sec_app && app_write_protect);
					cmd_go = !cmd_fail;
				end
				page_erase_cmd: begin
					cmd_fail = target == sec_app && app_write_protect;
					cmd_go = pb_any && !cmd_fail;
				end
				full_erase_cmd, eeprom_erase_cmd: cmd_go = 1'b1;
				fuse_write_cmd: begin
					cmd_fail = !dph_dbg;
					cmd_go = dph_dbg;
				end
				default: cmd_go = 1'b0;
			endcase
		end
	end

	// unlock window counted in retired instructions
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			key_left <= 3'h0;
		end else if (key_pulse) begin
			key_left <= KEY_WINDOW_INSTR;
		end else if (cmd_ok) begin
			key_left <= 3'h0;
		end else if (instr_done && key_left != 3'h0) begin
			key_left <= key_left - 3'h1;
		end
	end

	// command register holds the last accepted code
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			command <= '0;
		end else if (cmd_ok && state == st_idle) begin
			command <= wbyte[CMD_W-1:0];
		end
	end

	// sequencer: launch, wait for arrays, timed buffer clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= st_idle;
			stall_cnt <= 4'h0;
			run_cmd <= no_cmd;
		end else begin
			case (state)
				st_idle: begin
					if (cmd_ok && new_cmd == buffer_clear_cmd) begin
						state <= st_clear;
						stall_cnt <= PBC_STALL_CYCLES;
					end else if (cmd_go) begin
						state <= st_busy;
						run_cmd <= new_cmd;
					end
				end
				st_busy: begin
					if (nvm_rsp.done) begin
						state <= st_idle;
					end
				end
				st_clear: begin
					if (stall_cnt == 4'h1) begin
						state <= st_idle;
					end
					stall_cnt <= stall_cnt - 4'h1;
				end
				default: state <= st_idle;
			endcase
		end
	end
	assign cpu_stall = (state == st_clear);

	// request to the arrays, one start pulse per command
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nvm_req <= '0;
		end else begin
			nvm_req.start <= cmd_go;
			if (cmd_go) begin
				nvm_req.cmd <= new_cmd;
				nvm_req.to_eeprom <= target == sec_eeprom ||
					new_cmd == eeprom_erase_cmd;
				nvm_req.keep_eeprom <= eeprom_save_fuse;
				nvm_req.addr <= addr_word;
				nvm_req.data <= data_word;
			end
		end
	end

	// buffer clear after completed page operations or on command
	assign buf_clear = (state == st_idle && cmd_ok &&
		new_cmd == buffer_clear_cmd) ||
		(state == st_busy && nvm_rsp.done &&
		(run_cmd == page_write_cmd || run_cmd == page_erase_cmd ||
		run_cmd == erase_write_page_cmd));

	// page buffer contents and written marks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				page_buf[i] <= ERASED_BYTE;
			end
			pb_written <= '0;
		end else if (buf_clear) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				page_buf[i] <= ERASED_BYTE;
			end
			pb_written <= '0;
		end else if (pb_wr.valid) begin
			page_buf[pb_wr.addr[PB_AW-1:0]] <= pb_wr.data;
			pb_written[pb_wr.addr[PB_AW-1:0]] <= 1'b1;
		end
	end
	assign pb_any = |pb_written;

	// section of buffered bytes, mixing is an error
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pb_section <= sec_boot;
			pb_mixed <= 1'b0;
		end else if (buf_clear) begin
			pb_mixed <= 1'b0;
		end else if (pb_wr.valid) begin
			if (!pb_any) begin
				pb_section <= sec_of(pb_wr.addr);
			end else if (sec_of(pb_wr.addr) != pb_section) begin
				pb_mixed <= 1'b1;
			end
		end
	end

	// buffer read port for the arrays
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pb_rd_data <= BYTE_RESET;
			pb_rd_written <= 1'b0;
		end else begin
			pb_rd_data <= page_buf[pb_rd_idx];
			pb_rd_written <= pb_written[pb_rd_idx];
		end
	end

	// write error reflects the last operation only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			write_error <= 1'b0;
		end else if (cmd_fail) begin
			write_error <= 1'b1;
		end else if (cmd_go) begin
			write_error <= 1'b0;
		end else if (state == st_busy && nvm_rsp.done) begin
			write_error <= nvm_rsp.error;
		end
	end

	// protection bits, set only, reset clears
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			app_write_protect <= 1'b0;
			boot_lock_a <= 1'b0;
		end else if (dph_write && dph_idx == IDX_PROTECT) begin
			if (wbyte[APP_WP_BIT]) begin
				app_write_protect <= 1'b1;
			end
			if (wbyte[BOOT_LOCK_BIT] && in_boot) begin
				boot_lock_a <= 1'b1;
			end
		end
	end

	// lock arms on write, becomes active when boot is left
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_pending <= 1'b0;
			lock_active <= 1'b0;
		end else begin
			if (boot_lock_a && !lock_active) begin
				lock_pending <= 1'b1;
			end
			if ((lock_pending || boot_lock_a) && !in_boot) begin
				lock_active <= 1'b1;
			end
		end
	end

	// read and fetch gating for the boot section
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_data <= WORD_RESET;
		end else if (lock_active && sec_of(rd_addr) == sec_boot) begin
			rd_data <= WORD_RESET;
		end else begin
			rd_data <= mem_rdata;
		end
	end

	// interrupt enable and ready flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ready_irq_en <= 1'b0;
			eeprom_ready <= 1'b0;
		end else begin
			if (dph_write && dph_idx == IDX_IRQ_EN) begin
				ready_irq_en <= wbyte[EE_READY_BIT];
			end
			if (!nvm_rsp.eeprom_busy) begin
				eeprom_ready <= 1'b1;
			end else if (dph_write && dph_idx == IDX_IRQ_FLAGS &&
				wbyte[EE_READY_BIT]) begin
				eeprom_ready <= 1'b0;
			end
		end
	end
	assign eeprom_ready_irq = ready_irq_en && eeprom_ready;

	// data word, byte halves
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_word <= WORD_RESET;
		end else if (dph_write && dph_idx == IDX_DATA_LOW) begin
			data_word[7:0] <= wbyte;
		end else if (dph_write && dph_idx == IDX_DATA_HIGH) begin
			data_word[15:8] <= wbyte;
		end
	end

	// address word, follows buffer stores too
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_word <= WORD_RESET;
		end else if (pb_wr.valid) begin
			addr_word <= pb_wr.addr;
		end else if (dph_write && dph_idx == IDX_ADDR_LOW) begin
			addr_word[7:0] <= wbyte;
		end else if (dph_write && dph_idx == IDX_ADDR_HIGH) begin
			addr_word[15:8] <= wbyte;
		end
	end

	// register read mux
	always_comb begin
		rd_byte = BYTE_RESET;
		case (haddr[IDX_LSB +: IDX_W])
			IDX_COMMAND: rd_byte[CMD_W-1:0] = command;
			IDX_PROTECT: begin
				rd_byte[APP_WP_BIT] = app_write_protect;
				rd_byte[BOOT_LOCK_BIT] = boot_lock_a;
			end
			IDX_STATUS: begin
				rd_byte[FLASH_BUSY_BIT] = nvm_rsp.flash_busy;
				rd_byte[EE_BUSY_BIT] = nvm_rsp.eeprom_busy;
				rd_byte[WR_ERR_BIT] = write_error;
			end
			IDX_IRQ_EN: rd_byte[EE_READY_BIT] = ready_irq_en;
			IDX_IRQ_FLAGS: rd_byte[EE_READY_BIT] = eeprom_ready;
			IDX_DATA_LOW: rd_byte = data_word[7:0];
			IDX_DATA_HIGH: rd_byte = data_word[15:8];
			IDX_ADDR_LOW: rd_byte = addr_word[7:0];
			IDX_ADDR_HIGH: rd_byte = addr_word[15:8];
			default: rd_byte = BYTE_RESET;
		endcase
	end

	// read data registered at the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
			hrdata <= {24'h000000, rd_byte};
		end
	end
endmodule

/* src/nvm_pkg.sv */
package nvm_pkg;
	// register indices, byte address is four times the index
	localparam int IDX_W = 4;
	localparam int IDX_LSB = 2;
	localparam logic [3:0] IDX_COMMAND = 4'h0;
	localparam logic [3:0] IDX_PROTECT = 4'h1;
	localparam logic [3:0] IDX_STATUS = 4'h2;
	localparam logic [3:0] IDX_IRQ_EN = 4'h3;
	localparam logic [3:0] IDX_IRQ_FLAGS = 4'h4;
	localparam logic [3:0] IDX_DATA_LOW = 4'h6;
	localparam logic [3:0] IDX_DATA_HIGH = 4'h7;
	localparam logic [3:0] IDX_ADDR_LOW = 4'h8;
	localparam logic [3:0] IDX_ADDR_HIGH = 4'h9;
	// field positions
	localparam int APP_WP_BIT = 0;
	localparam int BOOT_LOCK_BIT = 1;
	localparam int FLASH_BUSY_BIT = 0;
	localparam int EE_BUSY_BIT = 1;
	localparam int WR_ERR_BIT = 2;
	localparam int EE_READY_BIT = 0;
	localparam int CMD_W = 3;
	// reset values and fills
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// timing and bus transfer code
	localparam logic [2:0] KEY_WINDOW_INSTR = 3'h4;
	localparam logic [3:0] PBC_STALL_CYCLES = 4'h7;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef enum logic [2:0] {
		no_cmd = 3'h0,
		page_write_cmd = 3'h1,
		page_erase_cmd = 3'h2,
		erase_write_page_cmd = 3'h3,
		buffer_clear_cmd = 3'h4,
		full_erase_cmd = 3'h5,
		eeprom_erase_cmd = 3'h6,
		fuse_write_cmd = 3'h7
	} nvm_cmd_t;
	typedef enum logic [1:0] {
		sec_boot = 2'h0,
		sec_app = 2'h1,
		sec_data = 2'h2,
		sec_eeprom = 2'h3
	} section_t;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_busy = 2'b01,
		st_clear = 2'b10
	} seq_state_t;
	// command handed to the arrays
	typedef struct packed {
		logic start;
		nvm_cmd_t cmd;
		logic to_eeprom;
		logic keep_eeprom;
		logic [15:0] addr;
		logic [15:0] data;
	} nvm_req_t;
	// answer from the arrays
	typedef struct packed {
		logic flash_busy;
		logic eeprom_busy;
		logic done;
		logic error;
	} nvm_rsp_t;
	// cpu store into the page buffer
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [7:0] data;
	} pb_wr_t;
endpackage

/* sim/nvm_array_model.sv */
`timescale 1ns/1ns
module nvm_array_model
	import nvm_pkg::*;
#(
	parameter int LAT = 20
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire nvm_pkg::nvm_req_t req,
	output nvm_pkg::nvm_rsp_t rsp
);
	int cnt;
	// arrays run a launched command for LAT cycles, then pulse done
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 0;
			rsp <= '0;
		end else begin
			rsp.done <= (cnt == 1) && !req.start;
			if (req.start) begin
				cnt <= LAT;
				rsp.flash_busy <= !req.to_eeprom;
				rsp.eeprom_busy <= req.to_eeprom;
			end else if (cnt == 1) begin
				cnt <= 0;
				rsp.flash_busy <= 1'b0;
				rsp.eeprom_busy <= 1'b0;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule

/* sim/nvm_command_register_interface_chk.sv */
`timescale 1ns/1ns
module nvm_command_register_interface_chk
	import nvm_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic dbg_master,
	input wire logic eeprom_save_fuse,
	input wire logic [7:0] pb_rd_data,
	input wire nvm_pkg::nvm_rsp_t nvm_rsp,
	input wire nvm_pkg::nvm_req_t nvm_req,
	input wire logic cpu_stall
);
	logic rd_ph;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// read address phase taken this edge
	assign rd_ph = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
	stall_len_a: assert property ($rose(cpu_stall)
		|-> cpu_stall[*7] ##1 !cpu_stall)
		else $error("stall length wrong");
	buf_fill_a: assert property ($rose(cpu_stall)
		|=> pb_rd_data == ERASED_BYTE)
		else $error("buffer not filled with ones");
	flash_stat_a: assert property (rd_ph && haddr[5:2] == IDX_STATUS
		|=> hrdata[FLASH_BUSY_BIT] == $past(nvm_rsp.flash_busy))
		else $error("flash busy status wrong");
	upper_zero_a: assert property (rd_ph |=> hrdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	fuse_dbg_a: assert property (nvm_req.start &&
		nvm_req.cmd == fuse_write_cmd |-> $past(dbg_master, 2))
		else $error("fuse write launched from cpu");
	chip_keep_a: assert property (nvm_req.start &&
		nvm_req.cmd == full_erase_cmd |->
		nvm_req.keep_eeprom == $past(eeprom_save_fuse))
		else $error("eeprom keep flag wrong");
	start_pulse_a: assert property (nvm_req.start |=> !nvm_req.start)
		else $error("start longer than one cycle");
	busy_hold_a: assert property (nvm_rsp.flash_busy ||
		nvm_rsp.eeprom_busy |-> !nvm_req.start)
		else $error("command launched while busy");
endmodule
bind nvm_command_register_interface nvm_command_register_interface_chk u_chk (.*);

/* sim/nvm_command_register_interface_bench.sv */
`timescale 1ns/1ns
module nvm_command_register_interface_bench;
	import nvm_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic hready, hreadyout, hresp, pb_rd_written, cpu_stall, eeprom_ready_irq;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, v;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic dbg_master = 0, key_pulse = 0, instr_done = 0, eeprom_save_fuse = 0;
	logic [15:0] cpu_pc = 16'h1000, rd_addr = 0, mem_rdata = 16'hA5C3, rd_data;
	logic [5:0] pb_rd_idx = 6'h03;
	logic [7:0] pb_rd_data;
	pb_wr_t pb_wr = '0;
	nvm_rsp_t nvm_rsp;
	nvm_req_t nvm_req, last_req;
	int bad_count, n_checks, cyc, starts;
	assign hready = hreadyout;
	nvm_command_register_interface u_nvm_command_register_interface (.hclk,
		.hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hresp, .hrdata, .dbg_master, .key_pulse, .instr_done,
		.cpu_pc, .eeprom_save_fuse, .pb_wr, .pb_rd_idx, .pb_rd_data,
		.pb_rd_written, .rd_addr, .mem_rdata, .rd_data, .nvm_rsp, .nvm_req,
		.cpu_stall, .eeprom_ready_irq);
	nvm_array_model u_nvm_array_model (.hclk, .hresetn, .req(nvm_req),
		.rsp(nvm_rsp));
	initial begin
		forever #10 hclk = ~hclk;
	end
	// launch monitor and hang guard
	always @(posedge hclk) begin
		cyc++;
		if (nvm_req.start === 1'b1) begin
			starts++;
			last_req = nvm_req;
		end
		if (cyc == 3000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one single word transfer, read data left in v
	task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {26'h0, idx, 2'h0};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (!hreadyout);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (!hreadyout);
		v = hrdata;
	endtask
	// unlock key followed by n retired instructions
	task automatic key(input int n);
		key_pulse <= 1'b1;
		@(posedge hclk);
		key_pulse <= 1'b0;
		if (n > 0) begin
			instr_done <= 1'b1;
			repeat (n) @(posedge hclk);
			instr_done <= 1'b0;
		end
	endtask
	// one buffer store, then an idle edge before the next store
	task automatic pb_store(input logic [15:0] a);
		pb_wr <= '{1'b1, a, 8'h5A};
		@(posedge hclk);
		pb_wr <= '0;
		@(posedge hclk);
	endtask
	task automatic wait_idle;
		repeat (3) @(posedge hclk);
		for (int i = 0; i < 60; i++) begin
			if (!nvm_rsp.flash_busy && !nvm_rsp.eeprom_busy) begin
				break;
			end
			@(posedge hclk);
		end
	endtask
	task automatic t_reset;
		logic [3:0] idx[9] = '{0, 1, 2, 3, 6, 7, 8, 9, 5};
		foreach (idx[i]) begin
			bus(0, idx[i], 0);
			chk(v, 0);
		end
		chk({hreadyout, hresp}, 2'b10);
		bus(0, IDX_IRQ_FLAGS, 0);
		chk(v, 1);
	endtask
	task automatic t_cmd;
		bus(1, IDX_COMMAND, page_write_cmd);
		bus(0, IDX_COMMAND, 0);
		chk(v, 0);
		key(4);
		bus(1, IDX_COMMAND, page_write_cmd);
		bus(0, IDX_COMMAND, 0);
		chk(v, 0);
		pb_store(16'h1003);
		repeat (2) @(posedge hclk);
		chk(pb_rd_written, 1);
		key(3);
		bus(1, IDX_COMMAND, page_erase_cmd);
		repeat (3) @(posedge hclk);
		bus(0, IDX_STATUS, 0);
		chk(v, 1);
		wait_idle();
		bus(0, IDX_STATUS, 0);
		chk(v, 0);
		chk(starts, 1);
		chk(last_req.cmd, page_erase_cmd);
		chk(pb_rd_written, 0);
		bus(0, IDX_ADDR_LOW, 0);
		chk(v, 32'h03);
		bus(0, IDX_ADDR_HIGH, 0);
		chk(v, 32'h10);
		key(1);
		bus(1, IDX_COMMAND, page_erase_cmd);
		repeat (3) @(posedge hclk);
		chk(starts, 1);
	endtask
	task automatic t_fuse;
		key(1);
		bus(1, IDX_COMMAND, fuse_write_cmd);
		repeat (3) @(posedge hclk);
		bus(0, IDX_STATUS, 0);
		chk(v, 4);
		chk(starts, 1);
		dbg_master <= 1'b1;
		bus(1, IDX_DATA_LOW, 32'hC4);
		bus(1, IDX_DATA_HIGH, 32'h7B);
		bus(1, IDX_COMMAND, fuse_write_cmd);
		wait_idle();
		dbg_master <= 1'b0;
		chk(last_req.data, 16'h7BC4);
		chk(last_req.cmd, fuse_write_cmd);
		bus(0, IDX_STATUS, 0);
		chk(v, 0);
	endtask
	task automatic t_erase_clear;
		int n;
		for (int f = 0; f < 2; f++) begin
			eeprom_save_fuse <= f[0];
			key(0);
			bus(1, IDX_COMMAND, full_erase_cmd);
			wait_idle();
			chk(last_req.keep_eeprom, f[0]);
		end
		pb_rd_idx <= 6'h05;
		pb_store(16'h1410);
		pb_store(16'h1005);
		key(1);
		bus(1, IDX_COMMAND, page_write_cmd);
		repeat (3) @(posedge hclk);
		bus(0, IDX_STATUS, 0);
		chk(v, 4);
		chk(starts, 4);
		key(2);
		bus(1, IDX_COMMAND, buffer_clear_cmd);
		n = 0;
		for (int i = 0; i < 20; i++) begin
			@(posedge hclk);
			n += cpu_stall;
		end
		chk(n, 7);
		chk({pb_rd_written, pb_rd_data}, 9'h0FF);
	endtask
	task automatic t_irq;
		key(0);
		bus(1, IDX_COMMAND, eeprom_erase_cmd);
		bus(1, IDX_IRQ_EN, 1);
		bus(1, IDX_IRQ_FLAGS, 1);
		@(posedge hclk);
		chk(eeprom_ready_irq, 0);
		bus(0, IDX_STATUS, 0);
		chk(v, 2);
		wait_idle();
		repeat (2) @(posedge hclk);
		chk(eeprom_ready_irq, 1);
		bus(1, IDX_IRQ_EN, 0);
		@(posedge hclk);
		chk(eeprom_ready_irq, 0);
		bus(1, IDX_IRQ_FLAGS, 1);
		bus(0, IDX_IRQ_FLAGS, 0);
		chk(v, 1);
	endtask
	task automatic t_protect;
		bus(1, IDX_PROTECT, 1);
		bus(1, IDX_PROTECT, 2);
		bus(0, IDX_PROTECT, 0);
		chk(v, 1);
		pb_store(16'h2000);
		key(1);
		bus(1, IDX_COMMAND, page_write_cmd);
		repeat (3) @(posedge hclk);
		bus(0, IDX_STATUS, 0);
		chk(v, 4);
		cpu_pc <= 16'h0100;
		rd_addr <= 16'h0040;
		bus(1, IDX_PROTECT, 2);
		bus(1, IDX_PROTECT, 0);
		bus(0, IDX_PROTECT, 0);
		chk(v, 3);
		chk(rd_data, 16'hA5C3);
		cpu_pc <= 16'h1000;
		repeat (3) @(posedge hclk);
		chk(rd_data, 0);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_cmd();
		t_fuse();
		t_erase_clear();
		t_irq();
		t_protect();
		finish_test();
	end
endmodule
